// file: rtl/slwr_pkg.sv
// package of constants and types for the supply loss and wake report block
package slwr_pkg;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] CHANNELS_OFF = 5'h00;
  localparam logic RESET_WAKE = 1'h0;
  typedef enum {
    SLWR_OFF,
    SLWR_NORMAL,
    SLWR_BATT_LOSS,
    SLWR_LOGIC_LOSS,
    SLWR_GND_LOSS
  } slwr_mode_type;
endpackage

// file: rtl/slwr_sync_if.sv
// interface carrying raw and synchronised supply indications
`timescale 1ns/1ps
`default_nettype none
interface slwr_sync_if;
  logic [2:0] raw;
  logic [2:0] synced;
  modport src(output raw, input synced);
  modport snk(input raw, output synced);
endinterface
`default_nettype wire

// file: rtl/slwr_sync.sv
// two flip-flop synchroniser for the supply indications
`timescale 1ns/1ps
`default_nettype none
module slwr_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  slwr_sync_if.snk sig
);
  logic [2:0] stage1_reg;
  logic [2:0] stage2_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage1_reg <= 3'h0;
      stage2_reg <= 3'h0;
    end else begin
      stage1_reg <= sig.raw;
      stage2_reg <= stage1_reg;
    end
  end
  assign sig.synced = stage2_reg;
endmodule
`default_nettype wire

// file: rtl/slwr_top.sv
// supply loss handling and wake state report on the clock pin
`timescale 1ns/1ps
`default_nettype none
module slwr_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic WAKE_IN,
  input wire logic DEVICE_RESET_INPUT_IN,
  input wire logic RESET_WAKE_IN,
  input wire logic BATTERY_SUPPLY_OK_IN,
  input wire logic LOGIC_SUPPLY_OK_IN,
  input wire logic LOGIC_SUPPLY_IN_RANGE_IN,
  input wire logic GROUND_OK_IN,
  input wire logic [4:0] CHANNEL_REQ_IN,
  input wire logic EXT_SWITCH_REQ_IN,
  input wire logic SERIAL_READ_REQ_IN,
  input wire logic [15:0] SERIAL_READ_DATA_IN,
  input wire logic COMM_FAULT_IN,
  output logic CLK_PIN_OUT,
  output logic CLK_PIN_OE_OUT,
  output logic OPERATIONAL_OUT,
  output logic [4:0] POWER_CHANNELS_ONE_TO_FIVE_OUT,
  output logic EXTERNAL_SWITCH_OUTPUT_OUT,
  output logic EXTERNAL_SWITCH_PULLUP_OUT,
  output logic SERIAL_DATA_VALID_OUT,
  output logic [15:0] SERIAL_DATA_OUT,
  output logic REG_CLEAR_OUT,
  output logic COMM_WATCHDOG_TIMEOUT_OUT,
  output logic FAIL_MODE_OUT
);
  slwr_sync_if sup();
  logic batt_ok;
  logic logic_ok;
  logic gnd_ok;
  slwr_pkg::slwr_mode_type mode_reg, mode_next;
  logic batt_lost_reg, batt_lost_next;
  logic clk_oe_reg, clk_oe_next;
  logic oper_reg, oper_next;
  logic [4:0] chan_reg, chan_next;
  logic ext_reg, ext_next;
  logic pull_reg, pull_next;
  logic vld_reg, vld_next;
  logic [15:0] data_reg, data_next;
  logic clr_reg, clr_next;
  logic wdt_reg, wdt_next;
  logic fail_reg, fail_next;

  assign sup.raw = {GROUND_OK_IN, LOGIC_SUPPLY_OK_IN, BATTERY_SUPPLY_OK_IN};
  slwr_sync u_sync (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .sig(sup)
  );
  assign batt_ok = sup.synced[0];
  assign logic_ok = sup.synced[1];
  assign gnd_ok = sup.synced[2];

  always_comb begin
    mode_next = slwr_pkg::SLWR_NORMAL;
    if (!gnd_ok) begin
      mode_next = slwr_pkg::SLWR_GND_LOSS;
    end else if (!batt_ok && !logic_ok) begin
      mode_next = slwr_pkg::SLWR_OFF;
    end else if (!batt_ok) begin
      mode_next = slwr_pkg::SLWR_BATT_LOSS;
    end else if (!logic_ok) begin
      mode_next = slwr_pkg::SLWR_LOGIC_LOSS;
    end
  end

  always_comb begin
    batt_lost_next = batt_lost_reg;
    clk_oe_next = 1'h0;
    oper_next = WAKE_IN;
    chan_next = slwr_pkg::CHANNELS_OFF;
    ext_next = ext_reg;
    pull_next = 1'h0;
    vld_next = 1'h0;
    data_next = data_reg;
    clr_next = 1'h0;
    wdt_next = wdt_reg;
    fail_next = fail_reg;
    // a report may only start after a full reset; battery loss latches it off
    case (mode_reg)
      slwr_pkg::SLWR_OFF: begin
        batt_lost_next = 1'h0;
        ext_next = 1'h0;
        data_next = 16'h0000;
        clr_next = 1'h1;
        wdt_next = 1'h0;
        fail_next = 1'h0;
        oper_next = 1'h0;
      end
      slwr_pkg::SLWR_BATT_LOSS: begin
        batt_lost_next = 1'h1;
        ext_next = EXT_SWITCH_REQ_IN;
        if (SERIAL_READ_REQ_IN && LOGIC_SUPPLY_IN_RANGE_IN) begin
          vld_next = 1'h1;
          data_next = SERIAL_READ_DATA_IN;
        end
      end
      slwr_pkg::SLWR_LOGIC_LOSS: begin
        wdt_next = 1'h1;
        ext_next = 1'h0;
        if (WAKE_IN) begin
          chan_next = CHANNEL_REQ_IN;
        end
      end
      slwr_pkg::SLWR_GND_LOSS: begin
        pull_next = 1'h1;
        ext_next = 1'h0;
      end
      slwr_pkg::SLWR_NORMAL: begin
        if (WAKE_IN) begin
          chan_next = CHANNEL_REQ_IN;
        end
        ext_next = EXT_SWITCH_REQ_IN;
        if (SERIAL_READ_REQ_IN) begin
          vld_next = 1'h1;
          data_next = SERIAL_READ_DATA_IN;
        end
        clk_oe_next = WAKE_IN && !DEVICE_RESET_INPUT_IN && !RESET_WAKE_IN && !batt_lost_reg;
      end
      default: begin
        clr_next = 1'h1;
      end
    endcase
    if (wdt_next || COMM_FAULT_IN) begin
      fail_next = 1'h1;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_reg <= slwr_pkg::SLWR_OFF;
      batt_lost_reg <= 1'h0;
      clk_oe_reg <= 1'h0;
      oper_reg <= slwr_pkg::RESET_WAKE;
      chan_reg <= slwr_pkg::CHANNELS_OFF;
      ext_reg <= 1'h0;
      pull_reg <= 1'h0;
      vld_reg <= 1'h0;
      data_reg <= 16'h0000;
      clr_reg <= 1'h1;
      wdt_reg <= 1'h0;
      fail_reg <= 1'h0;
    end else begin
      mode_reg <= mode_next;
      batt_lost_reg <= batt_lost_next;
      clk_oe_reg <= clk_oe_next;
      oper_reg <= oper_next;
      chan_reg <= chan_next;
      ext_reg <= ext_next;
      pull_reg <= pull_next;
      vld_reg <= vld_next;
      data_reg <= data_next;
      clr_reg <= clr_next;
      wdt_reg <= wdt_next;
      fail_reg <= fail_next;
    end
  end

  assign CLK_PIN_OUT = clk_oe_reg;
  assign CLK_PIN_OE_OUT = clk_oe_reg;
  assign OPERATIONAL_OUT = oper_reg;
  assign POWER_CHANNELS_ONE_TO_FIVE_OUT = chan_reg;
  assign EXTERNAL_SWITCH_OUTPUT_OUT = ext_reg;
  assign EXTERNAL_SWITCH_PULLUP_OUT = pull_reg;
  assign SERIAL_DATA_VALID_OUT = vld_reg;
  assign SERIAL_DATA_OUT = data_reg;
  assign REG_CLEAR_OUT = clr_reg;
  assign COMM_WATCHDOG_TIMEOUT_OUT = wdt_reg;
  assign FAIL_MODE_OUT = fail_reg;

  a_off_clears: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_OFF |=> REG_CLEAR_OUT && POWER_CHANNELS_ONE_TO_FIVE_OUT == 5'h00)
    else $error("power off did not clear");
  a_batt_chan_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_BATT_LOSS |=> POWER_CHANNELS_ONE_TO_FIVE_OUT == 5'h00 && !REG_CLEAR_OUT)
    else $error("battery loss kept channels on");
  a_no_report_after: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    batt_lost_reg |-> !CLK_PIN_OE_OUT)
    else $error("wake reported after battery loss");
  a_clk_reset_woken: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    RESET_WAKE_IN || !WAKE_IN |=> !CLK_PIN_OE_OUT)
    else $error("clock pin driven while asleep");
  a_clk_report_high: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_NORMAL && WAKE_IN && !DEVICE_RESET_INPUT_IN && !RESET_WAKE_IN && !batt_lost_reg
    |=> CLK_PIN_OE_OUT && CLK_PIN_OUT)
    else $error("wake not reported");
  a_read_needs_logic: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    SERIAL_DATA_VALID_OUT |-> $past(logic_ok))
    else $error("read data without logic supply");
  // fail is checked in the next cycle: a power off right after would clear it one cycle later
  a_logic_loss_wdt: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_LOGIC_LOSS |=> COMM_WATCHDOG_TIMEOUT_OUT && FAIL_MODE_OUT)
    else $error("no watchdog timeout on logic loss");
  a_gnd_loss: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_GND_LOSS |=> EXTERNAL_SWITCH_PULLUP_OUT && POWER_CHANNELS_ONE_TO_FIVE_OUT == 5'h00)
    else $error("ground loss handling wrong");
  a_sync_delay: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $fell(BATTERY_SUPPLY_OK_IN) ##1 !BATTERY_SUPPLY_OK_IN |=> !batt_ok)
    else $error("supply indication not synchronised in two cycles");

  // named steps of the supply and wake behaviour
  sequence s_normal_awake;
    mode_reg == slwr_pkg::SLWR_NORMAL && WAKE_IN;
  endsequence
  sequence s_normal_asleep;
    mode_reg == slwr_pkg::SLWR_NORMAL && !WAKE_IN;
  endsequence
  sequence s_normal_read;
    mode_reg == slwr_pkg::SLWR_NORMAL && SERIAL_READ_REQ_IN;
  endsequence
  sequence s_batt_read_ok;
    mode_reg == slwr_pkg::SLWR_BATT_LOSS && SERIAL_READ_REQ_IN && LOGIC_SUPPLY_IN_RANGE_IN;
  endsequence
  sequence s_supplies_gone;
    !batt_ok && !logic_ok && gnd_ok;
  endsequence
  sequence s_off_quiet;
    mode_reg == slwr_pkg::SLWR_OFF && !COMM_FAULT_IN;
  endsequence

  a_normal_chan: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_normal_awake |=> POWER_CHANNELS_ONE_TO_FIVE_OUT == $past(CHANNEL_REQ_IN))
    else $error("channels not following request while awake");
  a_sleep_chan_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_normal_asleep |=> POWER_CHANNELS_ONE_TO_FIVE_OUT == 5'h00 && !OPERATIONAL_OUT)
    else $error("channels on while asleep");
  a_oper_follows: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg != slwr_pkg::SLWR_OFF |=> OPERATIONAL_OUT == $past(WAKE_IN))
    else $error("operational flag not following wake");
  a_reset_pin_input: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    DEVICE_RESET_INPUT_IN |=> !CLK_PIN_OE_OUT)
    else $error("clock pin driven while reset pin asserted");
  a_clk_no_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg != slwr_pkg::SLWR_NORMAL |=> !CLK_PIN_OE_OUT)
    else $error("clock pin driven outside normal mode");
  a_normal_read: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_normal_read |=> SERIAL_DATA_VALID_OUT && SERIAL_DATA_OUT == $past(SERIAL_READ_DATA_IN))
    else $error("read data not returned in normal mode");
  a_logic_no_read: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_LOGIC_LOSS |=> !SERIAL_DATA_VALID_OUT)
    else $error("read data returned without logic supply");
  a_mode_power_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_supplies_gone |=> mode_reg == slwr_pkg::SLWR_OFF)
    else $error("both supplies lost without power off");
  a_off_clears_faults: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_off_quiet |=> !COMM_WATCHDOG_TIMEOUT_OUT && !FAIL_MODE_OUT && !EXTERNAL_SWITCH_OUTPUT_OUT)
    else $error("power off kept faults or outputs");
  a_batt_ext_follow: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_BATT_LOSS |=> EXTERNAL_SWITCH_OUTPUT_OUT == $past(EXT_SWITCH_REQ_IN))
    else $error("external switch not following configuration");
  a_batt_keeps_wdt: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_BATT_LOSS && COMM_WATCHDOG_TIMEOUT_OUT |=> COMM_WATCHDOG_TIMEOUT_OUT)
    else $error("fault lost during battery loss");
  a_batt_range_read: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    s_batt_read_ok |=> SERIAL_DATA_VALID_OUT && SERIAL_DATA_OUT == $past(SERIAL_READ_DATA_IN))
    else $error("status not reported during battery loss");
  a_batt_out_range: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_BATT_LOSS && !LOGIC_SUPPLY_IN_RANGE_IN |=> !SERIAL_DATA_VALID_OUT)
    else $error("read data with logic supply out of range");
  a_batt_latch: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_BATT_LOSS |=> batt_lost_reg)
    else $error("battery loss not remembered");
  a_gnd_no_read: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    mode_reg == slwr_pkg::SLWR_GND_LOSS |=> !SERIAL_DATA_VALID_OUT && !EXTERNAL_SWITCH_OUTPUT_OUT)
    else $error("outputs driven during ground loss");
  a_fault_fail: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    COMM_FAULT_IN |=> FAIL_MODE_OUT)
    else $error("communication fault did not enter fail mode");
  // fail mode is left only through power off
  a_fail_sticky: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    FAIL_MODE_OUT && mode_reg != slwr_pkg::SLWR_OFF |=> FAIL_MODE_OUT)
    else $error("fail mode left without power off");
endmodule
`default_nettype wire

// file: bench/slwr_mcu_model.sv
// microcontroller model issuing serial reads
`timescale 1ns/1ps
`default_nettype none
module slwr_mcu_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [15:0] word_in,
  output logic req_out,
  output logic [15:0] data_out
);
  // idle data inverts every cycle so a stale word never matches
  always @(posedge clk_in) begin
    req_out <= go_in;
    data_out <= go_in ? word_in : ~data_out;
  end
  initial begin
    req_out = 1'h0;
    data_out = 16'h0000;
  end
endmodule
`default_nettype wire

// file: bench/slwr_tb_top.sv
// testbench for the supply loss and wake report block
`timescale 1ns/1ps
`default_nettype none
module slwr_tb_top;
  logic clk = 0, rst = 1, wake = 0, rpin = 0, rwk = 0, bat = 1, lgc = 1, rng = 1, gnd = 1, ext = 0, flt = 0, go = 0;
  logic [4:0] creq = 0, ch;
  logic [15:0] word = 0, rdat, sdo;
  logic req, cpin, coe, oper, exo, pu, vld, clr, wdt, fail;
  logic [15:0] expq[$];
  int err_total = 0, cmp_count = 0;
  always #20 clk = ~clk;
  slwr_mcu_model i_mcu (.clk_in(clk), .go_in(go), .word_in(word), .req_out(req), .data_out(rdat));
  slwr_top i_dut (.CLK_IN(clk), .RST_IN(rst), .WAKE_IN(wake), .DEVICE_RESET_INPUT_IN(rpin),
    .RESET_WAKE_IN(rwk), .BATTERY_SUPPLY_OK_IN(bat), .LOGIC_SUPPLY_OK_IN(lgc), .LOGIC_SUPPLY_IN_RANGE_IN(rng),
    .GROUND_OK_IN(gnd), .CHANNEL_REQ_IN(creq), .EXT_SWITCH_REQ_IN(ext), .SERIAL_READ_REQ_IN(req),
    .SERIAL_READ_DATA_IN(rdat), .COMM_FAULT_IN(flt), .CLK_PIN_OUT(cpin), .CLK_PIN_OE_OUT(coe),
    .OPERATIONAL_OUT(oper), .POWER_CHANNELS_ONE_TO_FIVE_OUT(ch), .EXTERNAL_SWITCH_OUTPUT_OUT(exo),
    .EXTERNAL_SWITCH_PULLUP_OUT(pu), .SERIAL_DATA_VALID_OUT(vld), .SERIAL_DATA_OUT(sdo),
    .REG_CLEAR_OUT(clr), .COMM_WATCHDOG_TIMEOUT_OUT(wdt), .FAIL_MODE_OUT(fail));
  task automatic chkw(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chkw({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // supply indications pass two sync flops before use, so allow settling
  task automatic sup(input logic b, input logic l, input logic g);
    @(posedge clk);
    bat <= b;
    lgc <= l;
    gnd <= g;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rd(input int n, input logic ok);
    logic [15:0] w;
    repeat (n) begin
      @(posedge clk);
      w = 16'($urandom);
      word <= w;
      go <= 1'h1;
      if (ok) expq.push_back(w);
    end
    @(posedge clk);
    go <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  always @(negedge clk) if (!rst && vld === 1'h1) begin
    if (expq.size() == 0) chk1(1'h1, 1'h0);
    else chkw(sdo, expq.pop_front());
  end
  initial begin
    void'($urandom(32'h25b1a6e1));
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      wake <= i[0];
      rpin <= i[1];
      rwk <= i[2];
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk1(coe, i[0] & !i[1] & !i[2]);
      chk1(cpin, i[0] & !i[1] & !i[2]);
      chk1(oper, i[0]);
    end
    wake <= 1'h1;
    rpin <= 1'h0;
    rwk <= 1'h0;
    creq <= 5'($urandom);
    ext <= 1'h1;
    rd(3, 1'h1);
    chkw(16'(ch), 16'(creq));
    $display("wake and normal done");
    sup(1'h0, 1'h1, 1'h1);
    chkw(16'(ch), 16'h0000);
    chk1(exo, 1'h1);
    chk1(clr, 1'h0);
    rd(2, 1'h1);
    rng <= 1'h0;
    rd(1, 1'h0);
    rng <= 1'h1;
    sup(1'h1, 1'h1, 1'h1);
    chk1(coe, 1'h0);
    sup(1'h1, 1'h0, 1'h1);
    chk1(wdt, 1'h1);
    chk1(fail, 1'h1);
    rd(1, 1'h0);
    sup(1'h0, 1'h0, 1'h1);
    chk1(clr, 1'h1);
    chkw({9'h000, ch, exo, wdt}, 16'h0000);
    sup(1'h1, 1'h1, 1'h1);
    chk1(coe, 1'h1);
    chk1(fail, 1'h0);
    @(posedge clk);
    flt <= 1'h1;
    repeat (3) @(negedge clk);
    chk1(fail, 1'h1);
    @(posedge clk);
    flt <= 1'h0;
    $display("supply loss done");
    sup(1'h1, 1'h1, 1'h0);
    chkw(16'(ch), 16'h0000);
    chk1(pu, 1'h1);
    chk1(exo, 1'h0);
    rd(1, 1'h0);
    chkw(16'(expq.size()), 16'h0000);
    $display("ground loss done");
    results();
  end
  initial begin
    #200000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
